/* rxts_regs.sv */
`timescale 1ns/1ns
`include "rxts_map.svh"

// Contract
// - revision word read-only, writes ignored
// - scratch word read/write, resets to zero
// - three read-only identifier words, fixed
// - 20-bit clock period, ns.frac, reset period
// - 32-bit PMA delay, ns.frac, resets zero
module rxts_regs
  import rxts_pkg::*;
#(
  // arbitrary neutral values
  parameter logic [31:0] REVISION  = 32'h0000_0100,
  parameter logic [31:0] IDENT0    = 32'h5258_5453,
  parameter logic [31:0] IDENT1    = 32'h5F43_4647,
  parameter logic [31:0] IDENT2    = 32'h5F52_4547,
  parameter int          PER_W     = `RXTS_PER_WIDTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [11:0]      reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  input  wire logic             frame_start_i,
  output logic      [PER_W-1:0] per_used_o,
  output logic      [31:0]      dly_used_o
);

  // period field layout is fixed at 4.16
  if (PER_W != `RXTS_PER_WIDTH) begin : g_bad_per_w
    $error("clock period field must be 20 bits");
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  rxts_word_t       scratch_reg;
  rxts_word_t       scratch_next;
  logic [PER_W-1:0] per_reg;
  logic [PER_W-1:0] per_next;
  rxts_word_t       dly_reg;
  rxts_word_t       dly_next;
  rxts_word_t       rdata_reg;
  rxts_word_t       rdata_next;

  function automatic logic hit(input rxts_addr_t a, input rxts_addr_t o);
    hit = (a == o);
  endfunction : hit

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire wr_scratch = reg_wr_i && hit(reg_addr_i, `RXTS_OFF_SCRATCH);
  wire wr_per     = reg_wr_i && hit(reg_addr_i, `RXTS_OFF_CLK_PER);
  wire wr_dly     = reg_wr_i && hit(reg_addr_i, `RXTS_OFF_PMA_DLY);

  assign scratch_next = wr_scratch ? reg_wdata_i : scratch_reg;
  assign per_next     = wr_per ? reg_wdata_i[PER_W-1:0] : per_reg;
  assign dly_next     = wr_dly ? reg_wdata_i : dly_reg;

  wire rxts_word_t rd_mux =
    hit(reg_addr_i, `RXTS_OFF_REVISION) ? REVISION :
    hit(reg_addr_i, `RXTS_OFF_SCRATCH)  ? scratch_reg :
    hit(reg_addr_i, `RXTS_OFF_IDENT0)   ? IDENT0 :
    hit(reg_addr_i, `RXTS_OFF_IDENT1)   ? IDENT1 :
    hit(reg_addr_i, `RXTS_OFF_IDENT2)   ? IDENT2 :
    hit(reg_addr_i, `RXTS_OFF_CLK_PER)  ? {12'h000, per_reg} :
    hit(reg_addr_i, `RXTS_OFF_PMA_DLY)  ? dly_reg :
    32'h0000_0000;

  // data only in the cycle after the strobe
  assign rdata_next = reg_rd_i ? rd_mux : 32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      scratch_reg <= `RXTS_SCRATCH_RST;
      per_reg     <= PER_W'(`RXTS_PER_RST);
      dly_reg     <= `RXTS_PMA_DLY_RST;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      scratch_reg <= scratch_next;
      per_reg     <= per_next;
      dly_reg     <= dly_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ---------------------------------------------------------------
  // timestamp calibration hand-off
  // ---------------------------------------------------------------
  // latch at next frame
  rxts_cal_latch #(
    .PER_W         (PER_W)
  ) u_cal (
    .core_clk_i    (core_clk_i),
    .reset_n_i     (reset_n_i),
    .frame_start_i (frame_start_i),
    .per_cfg_i     (per_reg),
    .dly_cfg_i     (dly_reg),
    .per_used_o    (per_used_o),
    .dly_used_o    (dly_used_o)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_rev_readback: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `RXTS_OFF_REVISION |=> reg_rdata_o == REVISION)
    else $error("revision read wrong");

  a_scratch_write: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == `RXTS_OFF_SCRATCH ##1
    reg_rd_i && reg_addr_i == `RXTS_OFF_SCRATCH |=>
    reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("scratch readback wrong");

  a_scratch_reset: assert property (@(posedge core_clk_i)
    !reset_n_i |=> scratch_reg == 32'h0000_0000)
    else $error("scratch not cleared by reset");

  a_ident_fixed: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `RXTS_OFF_IDENT1 |=> reg_rdata_o == IDENT1)
    else $error("identifier word wrong");

  a_period_write: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    wr_per |=> per_reg == $past(reg_wdata_i[PER_W-1:0]))
    else $error("period not stored");

  a_period_upper: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `RXTS_OFF_CLK_PER |=>
    reg_rdata_o[31:20] == 12'h000)
    else $error("period upper bits not zero");

  a_delay_reset: assert property (@(posedge core_clk_i)
    !reset_n_i |=> dly_reg == 32'h0000_0000)
    else $error("delay not cleared by reset");

  a_delay_write: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    wr_dly ##1 !wr_dly |=> dly_reg == $past(reg_wdata_i, 2))
    else $error("delay not stored");

  a_idle_rdata: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    !reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");

  // ---------------------------------------------------------------
  // read path and storage checks
  // ---------------------------------------------------------------
  a_ident0_fixed: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `RXTS_OFF_IDENT0 |=> reg_rdata_o == IDENT0)
    else $error("first identifier word wrong");

  a_ident2_fixed: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `RXTS_OFF_IDENT2 |=> reg_rdata_o == IDENT2)
    else $error("last identifier word wrong");

  a_scratch_readback: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `RXTS_OFF_SCRATCH |=>
    reg_rdata_o == $past(scratch_reg))
    else $error("scratch read does not match stored word");

  a_period_readback: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `RXTS_OFF_CLK_PER |=>
    reg_rdata_o[PER_W-1:0] == $past(per_reg))
    else $error("period read does not match stored value");

  a_delay_readback: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `RXTS_OFF_PMA_DLY |=>
    reg_rdata_o == $past(dly_reg))
    else $error("delay read does not match stored value");

  a_period_reset: assert property (@(posedge core_clk_i)
    !reset_n_i |=> per_reg == PER_W'(`RXTS_PER_RST))
    else $error("period not restored by reset");

  a_scratch_holds: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    !wr_scratch |=> $stable(scratch_reg))
    else $error("scratch changed without a write");

  a_period_holds: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    !wr_per |=> $stable(per_reg))
    else $error("period changed without a write");

  a_delay_holds: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    !wr_dly |=> $stable(dly_reg))
    else $error("delay changed without a write");

  a_rev_no_write: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == `RXTS_OFF_REVISION |=>
    $stable(scratch_reg) && $stable(per_reg) && $stable(dly_reg))
    else $error("revision write altered storage");

  a_ident_no_write: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i >= `RXTS_OFF_IDENT0 &&
    reg_addr_i <= `RXTS_OFF_IDENT2 |=>
    $stable(scratch_reg) && $stable(per_reg) && $stable(dly_reg))
    else $error("identifier write altered storage");

  c_scratch_rw: cover property (@(posedge core_clk_i)
    wr_scratch ##1 reg_rd_i && reg_addr_i == `RXTS_OFF_SCRATCH);
  c_delay_frame: cover property (@(posedge core_clk_i)
    wr_dly ##[1:4] frame_start_i);
  c_period_frame: cover property (@(posedge core_clk_i)
    wr_per ##1 frame_start_i);
  c_ro_write: cover property (@(posedge core_clk_i)
    reg_wr_i && reg_addr_i == `RXTS_OFF_REVISION);
  c_mid_reset: cover property (@(posedge core_clk_i)
    wr_scratch ##[1:4] !reset_n_i);
endmodule : rxts_regs

/* rxts_map.svh */
`ifndef RXTS_MAP_SVH
`define RXTS_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define RXTS_OFF_REVISION 12'hB00
`define RXTS_OFF_SCRATCH  12'hB01
`define RXTS_OFF_IDENT0   12'hB02
`define RXTS_OFF_IDENT1   12'hB03
`define RXTS_OFF_IDENT2   12'hB04
`define RXTS_OFF_CLK_PER  12'hB05
`define RXTS_OFF_PMA_DLY  12'hB06

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define RXTS_PER_WIDTH    20
`define RXTS_PER_NS_MSB   19
`define RXTS_PER_NS_LSB   16
`define RXTS_FRAC_MSB     15
`define RXTS_DLY_NS_MSB   31
`define RXTS_DLY_NS_LSB   16
`define RXTS_SCRATCH_RST  32'h0000_0000
`define RXTS_PMA_DLY_RST  32'h0000_0000
`define RXTS_PER_RST      20'h2_8F5C
`define RXTS_RD_LATENCY   1

`endif

/* rxts_pkg.sv */
package rxts_pkg;
  typedef logic [31:0] rxts_word_t;
  typedef logic [11:0] rxts_addr_t;
  typedef enum logic [1:0] {
    RXTS_CAL_IDLE = 2'b00,
    RXTS_CAL_HOLD = 2'b01
  } rxts_cal_e;
endpackage : rxts_pkg

/* rxts_cal_latch.sv */
`timescale 1ns/1ns
`include "rxts_map.svh"

// per-frame snapshot of calibration values for the timestamp path
module rxts_cal_latch
  import rxts_pkg::*;
#(
  parameter int PER_W = `RXTS_PER_WIDTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             frame_start_i,
  input  wire logic [PER_W-1:0] per_cfg_i,
  input  wire logic [31:0]      dly_cfg_i,
  output logic      [PER_W-1:0] per_used_o,
  output logic      [31:0]      dly_used_o
);
  logic [PER_W-1:0] per_used_reg;
  logic [31:0]      dly_used_reg;

  // reset period needs 18 bits, a bus word caps it at 32
  if (PER_W < 18 || PER_W > 32) begin : g_bad_per_w
    $error("period width out of range");
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      per_used_reg <= PER_W'(`RXTS_PER_RST);
      dly_used_reg <= `RXTS_PMA_DLY_RST;
    end else if (frame_start_i) begin
      per_used_reg <= per_cfg_i;
      dly_used_reg <= dly_cfg_i;
    end
  end

  assign per_used_o = per_used_reg;
  assign dly_used_o = dly_used_reg;

  a_snap_on_frame: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    frame_start_i |=> (per_used_o == $past(per_cfg_i)) &&
                      (dly_used_o == $past(dly_cfg_i)))
    else $error("calibration snapshot not taken at frame start");

  a_snap_holds: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    !frame_start_i |=> $stable(per_used_o) && $stable(dly_used_o))
    else $error("calibration snapshot changed mid frame");
endmodule : rxts_cal_latch

/* rxts_regs_tb.sv */
`timescale 1ns/1ns

module rxts_regs_tb;
  import rxts_pkg::*;
  // arbitrary neutral identity values
  localparam logic [31:0] REV = 32'h0000_0A07;
  localparam logic [31:0] ID0 = 32'h4142_4344;
  localparam logic [31:0] ID1 = 32'h4546_4748;
  localparam logic [31:0] ID2 = 32'h494A_4B4C;

  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic [11:0] addr     = 12'h000;
  logic [31:0] wdata    = 32'h0000_0000;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        frame    = 1'b0;
  logic [31:0] rdata;
  logic [19:0] per_used;
  logic [31:0] dly_used;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  rxts_regs #(.REVISION(REV), .IDENT0(ID0), .IDENT1(ID1),
              .IDENT2(ID2)) dut (
    .core_clk_i    (clk),
    .reset_n_i     (rst_n),
    .reg_addr_i    (addr),
    .reg_wdata_i   (wdata),
    .reg_wr_i      (wr),
    .reg_rd_i      (rd),
    .reg_rdata_o   (rdata),
    .frame_start_i (frame),
    .per_used_o    (per_used),
    .dly_used_o    (dly_used)
  );

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // called on a rising edge; strobe stays up so that the next access
  // may follow with no gap, bus_idle drops it
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    wr    <= 1'b1;
    rd    <= 1'b0;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    wr   <= 1'b0;
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask : rd_chk

  task automatic bus_idle();
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus_idle

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({12'h000, per_used}, 32'h0002_8F5C);
    chk(dly_used, 32'h0000_0000);
    rd_chk(12'hB01, 32'h0000_0000);
    rd_chk(12'hB05, 32'h0002_8F5C);
    rd_chk(12'hB06, 32'h0000_0000);
  endtask : t_reset

  task automatic t_read_only();
    logic [11:0] ra[4];
    logic [31:0] rv[4];
    ra = '{12'hB00, 12'hB02, 12'hB03, 12'hB04};
    rv = '{REV, ID0, ID1, ID2};
    for (int i = 0; i < 4; i++) begin
      wr_reg(ra[i], ~rv[i]);
      rd_chk(ra[i], rv[i]);
    end
  endtask : t_read_only

  task automatic t_read_write();
    wr_reg(12'hB01, 32'hA5A5_5A5A);
    rd_chk(12'hB01, 32'hA5A5_5A5A);
    wr_reg(12'hB05, 32'hFFFF_FFFF);
    rd_chk(12'hB05, 32'h000F_FFFF);
    wr_reg(12'hB06, 32'h0003_FA1C);
    rd_chk(12'hB06, 32'h0003_FA1C);
  endtask : t_read_write

  task automatic t_frame();
    chk(dly_used, 32'h0000_0000);
    // write beside a frame start must not reach this frame
    frame <= 1'b1;
    wr_reg(12'hB06, 32'h1234_5678);
    frame <= 1'b0;
    wr_reg(12'hB05, 32'h0003_8000);
    frame <= 1'b1;
    wr    <= 1'b0;
    @(negedge clk);
    chk(dly_used, 32'h0003_FA1C);
    chk({12'h000, per_used}, 32'h000F_FFFF);
    @(posedge clk);
    frame <= 1'b0;
    @(negedge clk);
    chk(dly_used, 32'h1234_5678);
    chk({12'h000, per_used}, 32'h0003_8000);
    @(posedge clk);
  endtask : t_frame

  task automatic t_unmapped();
    wr_reg(12'hB07, 32'hFFFF_FFFF);
    rd_chk(12'hB07, 32'h0000_0000);
    rd_chk(12'hA01, 32'h0000_0000);
    rd_chk(12'hB01, 32'hA5A5_5A5A);
    @(negedge clk);
    chk(rdata, 32'h0000_0000);
    @(posedge clk);
  endtask : t_unmapped

  // reset in mid run must restore every stored and used value
  task automatic t_mid_reset();
    wr_reg(12'hB01, 32'h0F0F_0F0F);
    wr_reg(12'hB06, 32'h0003_FA1C);
    rst_n <= 1'b0;
    wr    <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(12'hB01, 32'h0000_0000);
    rd_chk(12'hB05, 32'h0002_8F5C);
    rd_chk(12'hB06, 32'h0000_0000);
    chk({12'h000, per_used}, 32'h0002_8F5C);
    chk(dly_used, 32'h0000_0000);
    bus_idle();
  endtask : t_mid_reset

  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_read_only();
    t_read_write();
    t_frame();
    t_unmapped();
    t_mid_reset();
    stop_test();
  end
endmodule : rxts_regs_tb
